//--- rtl/fcr_pkg.sv
// fcr_pkg: constants for the floppy configuration register bank.
// assumes an 8-bit index/data configuration port in front of the bank.
package fcr_pkg;
  // configuration port addresses (index port, data port one above it)
  localparam logic [15:0] CFG_INDEX_PORT = 16'h0026;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0027;
  // register indexes
  localparam logic [7:0] IDX_MODE_CTRL = 8'hf0;
  localparam logic [7:0] IDX_OPTION_CTRL = 8'hf1;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'hf2;
  localparam logic [7:0] IDX_RSVD_F3 = 8'hf3;
  localparam logic [7:0] IDX_DRIVE_ZERO = 8'hf4;
  localparam logic [7:0] IDX_RSVD_F5 = 8'hf5;
  // reset values
  localparam logic [7:0] RST_MODE_CTRL = 8'h0e;
  localparam logic [7:0] RST_OPTION_CTRL = 8'h00;
  localparam logic [7:0] RST_DRIVE_TYPE = 8'hff;
  localparam logic [7:0] RST_DRIVE_ZERO = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic RST_MAP_AT_MODE = 1'b1;
  localparam logic RST_MAP_DENSITY = 1'b1;
  // writable bit masks; cleared bits are reserved and read zero
  localparam logic [7:0] MASK_MODE_CTRL = 8'hdf;
  localparam logic [7:0] MASK_OPTION_CTRL = 8'h0d;
  localparam logic [7:0] MASK_DRIVE_TYPE = 8'hff;
  localparam logic [7:0] MASK_DRIVE_ZERO = 8'h5b;
  // mode register fields
  localparam int MODE_ENHANCED_BIT = 0;
  localparam int MODE_NONBURST_BIT = 1;
  localparam int MODE_IFACE_LSB = 2;
  localparam int MODE_SWAP_BIT = 4;
  localparam int MODE_PUSHPULL_BIT = 6;
  localparam int MODE_TRISTATE_BIT = 7;
  // interface mode codes
  localparam logic [1:0] IFACE_MODE_FIRST = 2'h3;
  localparam logic [1:0] IFACE_MODE_RSVD = 2'h2;
  localparam logic [1:0] IFACE_MODE_SECOND = 2'h1;
  localparam logic [1:0] IFACE_MODE_LEGACY = 2'h0;
  // option register fields
  localparam int OPT_FORCE_WP_BIT = 0;
  localparam int OPT_DENSITY_LSB = 2;
  // density codes
  localparam logic [1:0] DENS_NORMAL = 2'h0;
  localparam logic [1:0] DENS_NORMAL_USER = 2'h1;
  localparam logic [1:0] DENS_FORCE_ONE = 2'h2;
  localparam logic [1:0] DENS_FORCE_ZERO = 2'h3;
  // drive zero setup fields
  localparam int DRV_TYPE_LSB = 0;
  localparam int DRV_RATE_LSB = 3;
  localparam int DRV_PRECOMP_BIT = 6;
  // mapping view bit positions
  localparam int MAP_TRISTATE_BIT = 0;
  localparam int MAP_AT_MODE_BIT = 2;
  localparam int MAP_WP_BIT = 3;
  localparam int MAP_DENSITY_BIT = 5;
  localparam int MAP_ENHANCED_BIT = 6;
  // floppy pin lane order inside the pin stage
  localparam int PIN_DS0 = 0;
  localparam int PIN_DS1 = 1;
  localparam int PIN_MTR0 = 2;
  localparam int PIN_MTR1 = 3;
  localparam int PIN_DENS = 4;
  localparam int PIN_COUNT = 5;
  // input synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage : fcr_pkg

//--- rtl/fcr_pin_stage.sv
// fcr_pin_stage: floppy interface output stage with drive swap,
// open-drain / push-pull selection and tri-state control.
// assumes core-side levels on the same clock; pads resolve out/oe.
`timescale 1ns/1ps
module fcr_pin_stage
  import fcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls from the register bank
  input wire logic swapEn,
  input wire logic pushPull,
  input wire logic triState,
  // core-side levels, active low selects and motors
  input wire logic drive0_select_n,
  input wire logic drive1_select_n,
  input wire logic motor0_on_n,
  input wire logic motor1_on_n,
  input wire logic densityLevel,
  // pad side
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOe
);

  logic [PIN_COUNT-1:0] level;
  logic [PIN_COUNT-1:0] nxt_pinOut;
  logic [PIN_COUNT-1:0] nxt_pinOe;
  logic [PIN_COUNT-1:0] pinOut_ff;
  logic [PIN_COUNT-1:0] pinOe_ff;

  // drive 0 and drive 1 trade select and motor lanes when swapped
  assign level[PIN_DS0] = swapEn ? drive1_select_n : drive0_select_n;
  assign level[PIN_DS1] = swapEn ? drive0_select_n : drive1_select_n;
  assign level[PIN_MTR0] = swapEn ? motor1_on_n : motor0_on_n;
  assign level[PIN_MTR1] = swapEn ? motor0_on_n : motor1_on_n;
  assign level[PIN_DENS] = densityLevel;

  // open drain only pulls low; tri-state overrides both buffer types
  assign nxt_pinOut = pushPull ? level : '0;
  assign nxt_pinOe = triState ? '0 : (pushPull ? '1 : ~level);

  // registered pads avoid glitches when the swap or buffer type changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_ff <= '0;
      pinOe_ff <= '0;
    end else begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOe = pinOe_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_swap_select_lane: assert property (
    (swapEn && pushPull && !triState) |=> pinOut[PIN_DS0] == $past(drive1_select_n))
    else $error("swapped drive 0 select lane does not carry drive 1");
  chk_noswap_motor_lane: assert property (
    (!swapEn && pushPull && !triState) |=> pinOut[PIN_MTR0] == $past(motor0_on_n))
    else $error("unswapped motor lane wrong");
  chk_open_drain_high: assert property (
    (!pushPull && !triState) |=> pinOut == '0 && pinOe == ~$past(level))
    else $error("open drain lane drives a high level");
  chk_tristate_all_off: assert property (
    triState |=> pinOe == '0)
    else $error("output enabled while tri-stated");

  cov_swap_driven: cover property (swapEn && !triState ##1 pinOe[PIN_DS0]);

endmodule : fcr_pin_stage

//--- rtl/fcr_config_bank.sv
// fcr_config_bank: floppy controller configuration register bank behind
// the index/data configuration port, with mapping mirror and pin control.
// assumes host port strobes on clk; rst_n is the combined hard reset.
//
// Notes on behaviour
// - Only hard resets restore defaults; soft resets leave all fields alone.
// - Mode bit 0 clear selects normal floppy mode, set selects enhanced mode 2.
// - Mode bit 1 clear enables DMA burst; set, the default, is non-burst.
// - Mode bits 3:2 select interface mode: 11 first, 01 second, 00 legacy.
// - Writing 10 or 00 to interface mode keeps the mirrored mode bit.
// - Mode bit 4 set swaps drive 0 select and motor with drive 1.
// - Mode bit 6 clear gives open-drain outputs; set gives push-pull.
// - Mode bit 7 set tri-states all floppy outputs; clear drives them.
// - Mode bits 0, 2, 3 and 7 are mirrored into the mapping view.
// - Option bit 0 forces write-protect active whenever either drive selected.
// - Write-protect to core is select-and-force of either drive, or the pin.
// - Option bits 3:2: 00/01 normal, 10 forces density 1, 11 forces 0.
// - Writing 10 to density keeps the mirrored density bit but still forces.
// - Option bits 0, 2, 3 mirrored; bits 1 and 7:4 are reserved.
// - Drive type store resets to 0xff; bits 1:0 hold drive A type.
// - Drive zero setup holds type select 1:0 and rate table 4:3.
// - Drive zero setup bit 6 set disables write precompensation.
// - Drive zero bits 2, 5, 7 and indexes f3, f5 read zero.
`timescale 1ns/1ps
module fcr_config_bank
  import fcr_pkg::*;
(
  // clock and hard reset (power-on of either supply or host bus reset)
  input wire logic clk,
  input wire logic rst_n,
  // software reset request, deliberately without effect on this bank
  input wire logic softReset,
  // configuration port: portSel 0 is the index port, 1 the data port
  input wire logic fdcSelected,
  input wire logic portSel,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  // controller core side
  input wire logic coreDrive0Sel_n,
  input wire logic coreDrive1Sel_n,
  input wire logic coreMotor0_n,
  input wire logic coreMotor1_n,
  input wire logic coreDensity,
  output logic coreWriteProtect,
  output logic floppyEnhanced,
  output logic dmaNonBurst,
  output logic [1:0] ifaceMode,
  output logic [1:0] driveATypeStore,
  output logic [1:0] drive_type_sel,
  output logic [1:0] rate_table_sel,
  output logic precomp_disable,
  // mirror of the mapping register view
  output logic [7:0] mapView,
  // floppy interface pins
  input wire logic write_protect_n,
  output logic [PIN_COUNT-1:0] floppyPinOut,
  output logic [PIN_COUNT-1:0] floppyPinOe
);

  // register state
  logic [7:0] index_ff;
  logic [7:0] mode_ff;
  logic [7:0] option_ff;
  logic [7:0] driveType_ff;
  logic [7:0] driveZero_ff;
  logic mapAtMode_ff;
  logic mapDensity_ff;
  logic [7:0] rdData_ff;
  logic wpCore_ff;
  logic [SYNC_STAGES-1:0] wpSync_ff;

  // decode of the port access
  logic idxWr;
  logic dataWr;
  logic dataRd;
  logic idxRd;
  logic modeWr;
  logic optionWr;
  logic typeWr;
  logic zeroWr;
  logic [1:0] wrIface;
  logic [1:0] wrDensity;
  logic [7:0] readSel;
  logic [7:0] nxt_rdData;
  logic [7:0] nxt_mode;
  logic [7:0] nxt_option;
  logic [7:0] nxt_driveType;
  logic [7:0] nxt_driveZero;
  logic nxt_mapAtMode;
  logic nxt_mapDensity;
  logic nxt_wpCore;
  logic wpPinActive;
  logic driveSelected0;
  logic driveSelected1;
  logic forceWp;
  logic [1:0] densityCode;
  logic densityToPins;

  // masked write keeps reserved and read-only bits at zero
  function automatic logic [7:0] masked_write(input logic [7:0] data,
                                             input logic [7:0] mask);
    masked_write = data & mask;
  endfunction : masked_write

  // index first, data one port above; the bank never sees a data access
  // unless its logical device is the selected one
  assign idxWr = ioWr && !portSel;
  assign idxRd = ioRd && !portSel;
  assign dataWr = ioWr && portSel && fdcSelected;
  assign dataRd = ioRd && portSel && fdcSelected;
  assign modeWr = dataWr && (index_ff == IDX_MODE_CTRL);
  assign optionWr = dataWr && (index_ff == IDX_OPTION_CTRL);
  assign typeWr = dataWr && (index_ff == IDX_DRIVE_TYPE);
  assign zeroWr = dataWr && (index_ff == IDX_DRIVE_ZERO);
  // f3 and f5 have no write decode at all, so writes there vanish

  // next register values; reserved bit 5 of the mode register is dropped
  assign nxt_mode = modeWr ? masked_write(ioWrData, MASK_MODE_CTRL) : mode_ff;
  assign nxt_option = optionWr ? masked_write(ioWrData, MASK_OPTION_CTRL) : option_ff;
  assign nxt_driveType = typeWr ? masked_write(ioWrData, MASK_DRIVE_TYPE) : driveType_ff;
  assign nxt_driveZero = zeroWr ? masked_write(ioWrData, MASK_DRIVE_ZERO) : driveZero_ff;

  // mirror bits that only follow some codes
  assign wrIface = ioWrData[MODE_IFACE_LSB +: 2];
  assign wrDensity = ioWrData[OPT_DENSITY_LSB +: 2];
  always_comb begin
    nxt_mapAtMode = mapAtMode_ff;
    if (modeWr && wrIface == IFACE_MODE_FIRST) begin
      nxt_mapAtMode = 1'b1;
    end else if (modeWr && wrIface == IFACE_MODE_SECOND) begin
      nxt_mapAtMode = 1'b0;
    end
    // reserved and legacy codes leave the mirror alone
  end

  always_comb begin
    nxt_mapDensity = mapDensity_ff;
    if (optionWr && wrDensity == DENS_NORMAL) begin
      nxt_mapDensity = 1'b1;
    end else if (optionWr && wrDensity == DENS_FORCE_ZERO) begin
      nxt_mapDensity = 1'b0;
    end
    // forced-one and user codes keep the mirror as it was
  end

  // index latch; index port writes go through regardless of the device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_ff <= RST_INDEX;
    end else if (idxWr) begin
      index_ff <= ioWrData;
    end
  end

  // bank state; softReset is not in this process on purpose
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= RST_MODE_CTRL;
      option_ff <= RST_OPTION_CTRL;
      driveType_ff <= RST_DRIVE_TYPE;
      driveZero_ff <= RST_DRIVE_ZERO;
      mapAtMode_ff <= RST_MAP_AT_MODE;
      mapDensity_ff <= RST_MAP_DENSITY;
    end else begin
      mode_ff <= nxt_mode;
      option_ff <= nxt_option;
      driveType_ff <= nxt_driveType;
      driveZero_ff <= nxt_driveZero;
      mapAtMode_ff <= nxt_mapAtMode;
      mapDensity_ff <= nxt_mapDensity;
    end
  end

  // read mux; unknown indexes and reserved f3/f5 answer zero
  always_comb begin
    case (index_ff)
      IDX_MODE_CTRL: readSel = mode_ff;
      IDX_OPTION_CTRL: readSel = option_ff;
      IDX_DRIVE_TYPE: readSel = driveType_ff;
      IDX_DRIVE_ZERO: readSel = driveZero_ff;
      default: readSel = 8'h00;
    endcase
  end

  // read data is captured on the strobe and held until the next read
  assign nxt_rdData = idxRd ? index_ff : (dataRd ? readSel : rdData_ff);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end
  assign ioRdData = rdData_ff;

  // field outputs straight from the register flops
  assign floppyEnhanced = mode_ff[MODE_ENHANCED_BIT];
  assign dmaNonBurst = mode_ff[MODE_NONBURST_BIT];
  assign ifaceMode = mode_ff[MODE_IFACE_LSB +: 2];
  assign driveATypeStore = driveType_ff[1:0];
  assign drive_type_sel = driveZero_ff[DRV_TYPE_LSB +: 2];
  assign rate_table_sel = driveZero_ff[DRV_RATE_LSB +: 2];
  assign precomp_disable = driveZero_ff[DRV_PRECOMP_BIT];

  // mapping view: bits 0, 3 and 6 are the same flops; AT mode and density bits are separate mirror flops
  assign mapView = {1'b0,
                    mode_ff[MODE_ENHANCED_BIT],
                    mapDensity_ff,
                    1'b0,
                    option_ff[OPT_FORCE_WP_BIT],
                    mapAtMode_ff,
                    1'b0,
                    mode_ff[MODE_TRISTATE_BIT]};

  // write-protect pin comes from a drive cable: two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wpSync_ff <= '1;
    end else begin
      wpSync_ff <= {wpSync_ff[SYNC_STAGES-2:0], write_protect_n};
    end
  end
  assign wpPinActive = !wpSync_ff[SYNC_STAGES-1];

  // forced protect applies only while a drive is selected
  assign driveSelected0 = !coreDrive0Sel_n;
  assign driveSelected1 = !coreDrive1Sel_n;
  assign forceWp = option_ff[OPT_FORCE_WP_BIT];
  assign nxt_wpCore = (driveSelected0 && forceWp) || (driveSelected1 && forceWp)
                      || wpPinActive;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wpCore_ff <= 1'b0;
    end else begin
      wpCore_ff <= nxt_wpCore;
    end
  end
  assign coreWriteProtect = wpCore_ff;

  // density override; the mirror may disagree after a forced-one write
  assign densityCode = option_ff[OPT_DENSITY_LSB +: 2];
  assign densityToPins = (densityCode == DENS_FORCE_ONE) ? 1'b1 :
                         (densityCode == DENS_FORCE_ZERO) ? 1'b0 : coreDensity;

  // pad stage holds swap, buffer type and tri-state
  fcr_pin_stage fcr_pin_stage_inst (
    .clk(clk),
    .rst_n(rst_n),
    .swapEn(mode_ff[MODE_SWAP_BIT]),
    .pushPull(mode_ff[MODE_PUSHPULL_BIT]),
    .triState(mode_ff[MODE_TRISTATE_BIT]),
    .drive0_select_n(coreDrive0Sel_n),
    .drive1_select_n(coreDrive1Sel_n),
    .motor0_on_n(coreMotor0_n),
    .motor1_on_n(coreMotor1_n),
    .densityLevel(densityToPins),
    .pinOut(floppyPinOut),
    .pinOe(floppyPinOe)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_soft_reset_ignored: assert property (
    (softReset && !dataWr) |=> $stable(mode_ff) && $stable(option_ff) && $stable(driveZero_ff))
    else $error("soft reset disturbed the bank");
  chk_mode_enhanced: assert property (
    modeWr |=> floppyEnhanced == $past(ioWrData[0]))
    else $error("floppy mode bit not taken from write");
  chk_mode_nonburst: assert property (
    modeWr |=> dmaNonBurst == $past(ioWrData[1]))
    else $error("dma mode bit not taken from write");
  chk_iface_written: assert property (
    modeWr |=> ifaceMode == $past(ioWrData[3:2]))
    else $error("interface mode not taken from write");
  chk_iface_mirror_hold: assert property (
    (modeWr && !ioWrData[2]) |=> $stable(mapAtMode_ff))
    else $error("mirror moved on reserved or legacy code");
  chk_reserved_bit5: assert property (
    modeWr |=> mode_ff[5] == 1'b0)
    else $error("reserved mode bit stored");
  chk_mirror_at_mode: assert property (
    (modeWr && ioWrData[3:2] == 2'h3) |=> mapView[2] ##1 mapView[2] || $past(modeWr))
    else $error("first mode not mirrored");
  chk_force_wp: assert property (
    (forceWp && driveSelected1 && !optionWr) |=> coreWriteProtect)
    else $error("forced write protect missing with drive selected");
  chk_wp_pin_path: assert property (
    (!driveSelected0 && !driveSelected1 && !wpPinActive) |=> !coreWriteProtect)
    else $error("write protect active without cause");
  chk_density_force: assert property (
    densityCode == DENS_FORCE_ZERO |-> !densityToPins)
    else $error("density not forced to zero");
  chk_density_mirror: assert property (
    (optionWr && ioWrData[3:2] == 2'h2) |=> $stable(mapDensity_ff) ##0 densityToPins)
    else $error("forced one changed mirror or did not force");
  chk_option_reserved: assert property (
    optionWr |=> (option_ff & 8'hf2) == 8'h00)
    else $error("reserved option bits stored");
  chk_zero_ro_bits: assert property (
    zeroWr |=> driveZero_ff[2] == 1'b0 && driveZero_ff[5] == 1'b0 && driveZero_ff[7] == 1'b0)
    else $error("read-only drive zero bits stored");
  chk_rsvd_read_zero: assert property (
    (dataRd && (index_ff == IDX_RSVD_F3 || index_ff == IDX_RSVD_F5)) |=> ioRdData == 8'h00)
    else $error("reserved index read not zero");
  chk_precomp_write: assert property (
    zeroWr |=> precomp_disable == $past(ioWrData[6]))
    else $error("precompensation disable not stored");

  cov_force_wp: cover property (forceWp && driveSelected0 ##1 coreWriteProtect);
  cov_density_one: cover property (densityCode == DENS_FORCE_ONE);
  cov_swap_mode: cover property (modeWr && ioWrData[4]);
  cov_legacy_mode: cover property (modeWr && ioWrData[3:2] == 2'h0);

endmodule : fcr_config_bank

//--- dv/tb_fcr_config_bank.sv
// tb_fcr_config_bank: self-checking bench for the floppy configuration bank.
// assumes the bank alone, driven from its own ports on a 25 MHz clock.
`timescale 1ns/1ps
module tb_fcr_config_bank
  import fcr_pkg::*;
;
  // clock, resets and configuration port
  logic clk, rst_n, softReset, fdcSelected, portSel, ioWr, ioRd;
  logic [7:0] ioWrData, ioRdData, mapView;
  // core side and pins
  logic coreDrive0Sel_n, coreDrive1Sel_n, coreMotor0_n, coreMotor1_n, coreDensity;
  logic coreWriteProtect, floppyEnhanced, dmaNonBurst, precomp_disable, write_protect_n;
  logic [1:0] ifaceMode, driveATypeStore, drive_type_sel, rate_table_sel;
  logic [PIN_COUNT-1:0] floppyPinOut, floppyPinOe;
  int err_total = 0;
  int cmp_count = 0;

  fcr_config_bank fcr_config_bank_inst (
    .clk(clk), .rst_n(rst_n), .softReset(softReset), .fdcSelected(fdcSelected),
    .portSel(portSel), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .coreDrive0Sel_n(coreDrive0Sel_n), .coreDrive1Sel_n(coreDrive1Sel_n),
    .coreMotor0_n(coreMotor0_n), .coreMotor1_n(coreMotor1_n), .coreDensity(coreDensity),
    .coreWriteProtect(coreWriteProtect), .floppyEnhanced(floppyEnhanced),
    .dmaNonBurst(dmaNonBurst), .ifaceMode(ifaceMode), .driveATypeStore(driveATypeStore),
    .drive_type_sel(drive_type_sel), .rate_table_sel(rate_table_sel),
    .precomp_disable(precomp_disable), .mapView(mapView), .write_protect_n(write_protect_n),
    .floppyPinOut(floppyPinOut), .floppyPinOe(floppyPinOe)
  );

  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // let registered fields and the pin stage settle before sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // one strobe on the index (0) or data (1) port
  task automatic portWr(input logic ps, input logic [7:0] d);
    @(posedge clk);
    portSel <= ps;
    ioWrData <= d;
    ioWr <= 1'b1;
    @(posedge clk);
    ioWr <= 1'b0;
  endtask : portWr

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    portWr(1'b0, idx);
    portWr(1'b1, d);
  endtask : wreg

  task automatic rdreg(input string name, input logic [7:0] idx, input logic [7:0] exp);
    portWr(1'b0, idx);
    @(posedge clk);
    portSel <= 1'b1;
    ioRd <= 1'b1;
    @(posedge clk);
    ioRd <= 1'b0;
    step(1);
    check(name, exp, ioRdData);
  endtask : rdreg

  // every index reads its hard reset value; reserved ones read zero
  task automatic resetValues();
    rdreg("modeCtrl", IDX_MODE_CTRL, 8'h0e);
    rdreg("optionCtrl", IDX_OPTION_CTRL, 8'h00);
    rdreg("driveType", IDX_DRIVE_TYPE, 8'hff);
    rdreg("rsvdF3", IDX_RSVD_F3, 8'h00);
    rdreg("driveZero", IDX_DRIVE_ZERO, 8'h00);
    rdreg("rsvdF5", IDX_RSVD_F5, 8'h00);
    check("mapView", 8'h24, mapView);
    check("dmaNonBurst", 8'h01, 8'(dmaNonBurst));
    check("ifaceMode", 8'h03, 8'(ifaceMode));
  endtask : resetValues

  // all ones everywhere: only writable bits stick, soft reset and deselect do nothing
  task automatic allOnes();
    // software keeps reserved mode bit 5 at zero, so the mode write is 0xdf
    for (int i = 0; i < 6; i++) wreg(8'hf0 + 8'(i), (i == 0) ? 8'hdf : 8'hff);
    rdreg("modeOnes", IDX_MODE_CTRL, 8'hdf);
    rdreg("optionOnes", IDX_OPTION_CTRL, 8'h0d);
    rdreg("typeOnes", IDX_DRIVE_TYPE, 8'hff);
    rdreg("f3Ones", IDX_RSVD_F3, 8'h00);
    rdreg("zeroOnes", IDX_DRIVE_ZERO, 8'h5b);
    rdreg("f5Ones", IDX_RSVD_F5, 8'h00);
    check("fieldsOnes", 8'hff, {floppyEnhanced, dmaNonBurst, driveATypeStore, drive_type_sel,
      rate_table_sel});
    check("precompOff", 8'h01, 8'(precomp_disable));
    check("mapOnes", 8'h4d, mapView);
    check("oeTriState", 8'h00, 8'(floppyPinOe));
    @(posedge clk);
    softReset <= 1'b1;
    fdcSelected <= 1'b0;
    wreg(IDX_MODE_CTRL, 8'h00);
    softReset <= 1'b0;
    fdcSelected <= 1'b1;
    rdreg("modeKept", IDX_MODE_CTRL, 8'hdf);
    check("mapKept", 8'h4d, mapView);
    // the index port reads back the index last written
    @(posedge clk);
    portSel <= 1'b0;
    ioRd <= 1'b1;
    @(posedge clk);
    ioRd <= 1'b0;
    step(1);
    check("indexRead", IDX_MODE_CTRL, ioRdData);
  endtask : allOnes

  // interface codes 01,10,11,00: mirror clears, keeps, sets, keeps
  task automatic ifaceCodes();
    logic [1:0] code [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic mir [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wreg(IDX_MODE_CTRL, {4'h0, code[i], 2'h0});
      step(2);
      check("ifaceMode", 8'(code[i]), 8'(ifaceMode));
      check("dmaBurst", 8'h00, 8'(dmaNonBurst));
      check("mapAtMode", 8'(mir[i]), 8'(mapView[2]));
    end
  endtask : ifaceCodes

  // density codes with push-pull pins and the core density held low
  task automatic densityCodes();
    logic [1:0] code [5] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h2};
    logic mir [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic pad [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    wreg(IDX_MODE_CTRL, 8'h40);
    for (int i = 0; i < 5; i++) begin
      wreg(IDX_OPTION_CTRL, {4'h0, code[i], 2'h0});
      step(3);
      check("mapDensity", 8'(mir[i]), 8'(mapView[5]));
      check("densityPad", 8'(pad[i]), 8'(floppyPinOut[PIN_DENS]));
    end
  endtask : densityCodes

  // drive 1 selected with its motor on, through swap, buffer type and tri-state
  task automatic pinModes();
    logic [7:0] mode [4] = '{8'h50, 8'h10, 8'h90, 8'h40};
    logic [4:0] expOut [4] = '{5'h0a, 5'h00, 5'h00, 5'h05};
    logic [4:0] expOe [4] = '{5'h1f, 5'h15, 5'h00, 5'h1f};
    wreg(IDX_OPTION_CTRL, 8'h00);
    coreDrive1Sel_n <= 1'b0;
    coreMotor1_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wreg(IDX_MODE_CTRL, mode[i]);
      step(3);
      check("pinOut", 8'(expOut[i]), 8'(floppyPinOut));
      check("pinOe", 8'(expOe[i]), 8'(floppyPinOe));
    end
    @(posedge clk) coreDrive1Sel_n <= 1'b1;
    coreMotor1_n <= 1'b1;
  endtask : pinModes

  // forced write protect per drive, then the pin alone
  task automatic writeProtect();
    wreg(IDX_OPTION_CTRL, 8'h01);
    step(2);
    check("wpIdle", 8'h00, 8'(coreWriteProtect));
    check("mapWp", 8'h01, 8'(mapView[3]));
    @(posedge clk) coreDrive0Sel_n <= 1'b0;
    step(2);
    check("wpDrive0", 8'h01, 8'(coreWriteProtect));
    @(posedge clk) coreDrive0Sel_n <= 1'b1;
    coreDrive1Sel_n <= 1'b0;
    step(2);
    check("wpDrive1", 8'h01, 8'(coreWriteProtect));
    wreg(IDX_OPTION_CTRL, 8'h00);
    step(2);
    check("wpUnforced", 8'h00, 8'(coreWriteProtect));
    @(posedge clk) write_protect_n <= 1'b0;
    step(4);
    check("wpPin", 8'h01, 8'(coreWriteProtect));
    @(posedge clk) write_protect_n <= 1'b1;
    coreDrive1Sel_n <= 1'b1;
  endtask : writeProtect

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    softReset = 1'b0;
    fdcSelected = 1'b1;
    portSel = 1'b0;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 8'h00;
    {coreDrive0Sel_n, coreDrive1Sel_n, coreMotor0_n, coreMotor1_n} = 4'hf;
    coreDensity = 1'b0;
    write_protect_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    resetValues();
    allOnes();
    ifaceCodes();
    densityCodes();
    pinModes();
    writeProtect();
    // hard reset in mid-run restores every default
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    resetValues();
    print_verdict();
  end
endmodule : tb_fcr_config_bank
